// file: rtl/dsc_pkg.sv
// package of constants for the diagnostic status collector
package dsc_pkg;
    // ==========================================================
    // register indices and byte addresses (index times four)
    localparam logic [3:0]  DSC_IDX_MEM_ALARM = 4'h3;
    localparam logic [3:0]  DSC_IDX_IO_SUPPLY = 4'h8;
    localparam logic [3:0]  DSC_IDX_ENCODER   = 4'hD;
    localparam logic [11:0] DSC_OFF_MEM_ALARM = 12'h00C;
    localparam logic [11:0] DSC_OFF_IO_SUPPLY = 12'h020;
    localparam logic [11:0] DSC_OFF_ENCODER   = 12'h034;
    localparam logic [11:0] DSC_OFF_IRQ_EN    = 12'h040;
    localparam logic [11:0] DSC_OFF_ENC_CFG   = 12'h044;
    localparam logic [11:0] DSC_OFF_DIAG_IRQ  = 12'h048;
    // ==========================================================
    // field positions
    localparam int DSC_BIT_CPU_FAIL   = 1;
    localparam int DSC_BIT_FLASH_FAIL = 2;
    localparam int DSC_BIT_RAM_FAIL   = 3;
    localparam int DSC_BIT_Q_OVERRUN  = 6;
    localparam int DSC_BIT_IO_SUPPLY  = 5;
    localparam int DSC_BIT_WIRE_BREAK = 0;
    localparam int DSC_BIT_FRAME_ERR  = 1;
    localparam int DSC_BIT_ENC_SUPPLY = 3;
    // interrupt enable bits
    localparam int DSC_IE_Q_OVERRUN  = 0;
    localparam int DSC_IE_IO_SUPPLY  = 1;
    localparam int DSC_IE_WIRE_BREAK = 2;
    localparam int DSC_IE_FRAME_ERR  = 3;
    localparam int DSC_IE_ENC_SUPPLY = 4;
    // ==========================================================
    // reset values and timing
    localparam logic [7:0]  DSC_RST_BYTE   = 8'h00;
    localparam logic [4:0]  DSC_RST_IE     = 5'h00;
    localparam logic [1:0]  DSC_RST_ENC    = 2'h0;
    localparam int          DSC_CLK_MHZ    = 100;
    localparam int          DSC_FRAME_TO_US = 40;
    localparam int          DSC_FRAME_TO_CYC = DSC_FRAME_TO_US * DSC_CLK_MHZ;
    // ==========================================================
    // encoder selection
    typedef enum logic [1:0] {
        DSC_ENC_NONE   = 2'h0,
        DSC_ENC_DIFF   = 2'h1,
        DSC_ENC_SERIAL = 2'h2
    } dsc_enc_e;
endpackage : dsc_pkg

// file: rtl/dsc_sync.sv
// three-stage pin synchroniser with agreement check
`timescale 1ns/100ps
module dsc_sync
    import dsc_pkg::*;
#(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] dout_nxt;

    // change counts once stages two and three agree
    assign dout_nxt = (s2_r & s3_r) | (dout & (s2_r | s3_r));

    // ==========================================================
    // shift chain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            dout <= '0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            dout <= dout_nxt;
        end
    end
endmodule // dsc_sync

// file: rtl/dsc_frame_mon.sv
// serial encoder frame watchdog and format check
`timescale 1ns/100ps
module dsc_frame_mon
    import dsc_pkg::*;
#(
    parameter int TIMEOUT = DSC_FRAME_TO_CYC
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic active,
    input  wire logic frame_done,
    input  wire logic frame_bad,
    output logic      frame_err
);
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic        bad_r;
    logic        bad_nxt;
    logic        stale;

    // no frame within the timeout counts as missing data
    assign stale   = (cnt_r >= 16'(TIMEOUT));
    assign cnt_nxt = (!active || frame_done) ? 16'h0000 :
                     stale ? cnt_r : cnt_r + 16'h0001;
    assign bad_nxt = !active ? 1'b0 : frame_done ? frame_bad : bad_r;
    assign frame_err = active && (bad_r || stale);

    // ==========================================================
    // counter and last-frame verdict
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 16'h0000;
            bad_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            bad_r <= bad_nxt;
        end
    end
endmodule // dsc_frame_mon

// file: rtl/dsc_top.sv
// diagnostic status collector with apb register access
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
module dsc_top
    import dsc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cpu_test_fail,
    input  wire logic        flash_test_fail,
    input  wire logic        ram_test_fail,
    input  wire logic        host_queue_overrun,
    input  wire logic        local_queue_overrun,
    input  wire logic        io_supply_input,
    input  wire logic [2:0]  diff_pair_fault,
    input  wire logic        high_supply_overload,
    input  wire logic        low_supply_overload,
    input  wire logic        frame_done,
    input  wire logic        frame_bad,
    output logic             io_fault_lamp,
    output logic             high_supply_fault_lamp,
    output logic             low_supply_fault_lamp,
    output logic             diag_irq
);
    // ==========================================================
    // pin synchronisers
    logic [7:0] pins_raw;
    logic [7:0] pins_s;
    logic       fdone_s;
    logic       fbad_s;

    assign pins_raw = {low_supply_overload, high_supply_overload,
                       diff_pair_fault, io_supply_input,
                       local_queue_overrun, host_queue_overrun};

    dsc_sync #(.W(8)) u_sync_pins (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (pins_raw),
        .dout    (pins_s)
    );

    dsc_sync #(.W(2)) u_sync_frame (
        .pclk    (pclk),
        .presetn (presetn),
        .din     ({frame_bad, frame_done}),
        .dout    ({fbad_s, fdone_s})
    );

    // ==========================================================
    // done edge so each frame counts once
    logic fdone_d_r;
    logic fdone_pulse;
    assign fdone_pulse = fdone_s && !fdone_d_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fdone_d_r <= 1'b0;
        end else begin
            fdone_d_r <= fdone_s;
        end
    end

    // ==========================================================
    // configuration registers
    logic [4:0] irq_en_r;
    logic [1:0] enc_sel_r;
    logic       serial_sel;
    assign serial_sel = (enc_sel_r == DSC_ENC_SERIAL);

    // ==========================================================
    // serial frame watchdog
    logic frame_err;

    dsc_frame_mon u_frame_mon (
        .pclk       (pclk),
        .presetn    (presetn),
        .active     (serial_sel),
        .frame_done (fdone_pulse),
        .frame_bad  (fbad_s),
        .frame_err  (frame_err)
    );

    // ==========================================================
    // live fault conditions
    logic q_overrun;
    logic io_missing;
    logic wire_break;
    logic enc_supply;
    logic [2:0] pair_mask;

    assign q_overrun  = pins_s[0] | pins_s[1];
    assign io_missing = !pins_s[2];
    assign pair_mask  = serial_sel ? 3'h1 : 3'h7;
    assign wire_break = |(pins_s[5:3] & pair_mask);
    assign enc_supply = pins_s[6] | pins_s[7];

    // ==========================================================
    // diagnostic byte next values, live status
    logic [7:0] mem_nxt;
    logic [7:0] io_nxt;
    logic [7:0] enc_nxt;

    always_comb begin
        mem_nxt = DSC_RST_BYTE;
        mem_nxt[DSC_BIT_CPU_FAIL]   = cpu_test_fail;
        mem_nxt[DSC_BIT_FLASH_FAIL] = flash_test_fail;
        mem_nxt[DSC_BIT_RAM_FAIL]   = ram_test_fail;
        mem_nxt[DSC_BIT_Q_OVERRUN]  = q_overrun;
        io_nxt = DSC_RST_BYTE;
        io_nxt[DSC_BIT_IO_SUPPLY]   = io_missing;
        enc_nxt = DSC_RST_BYTE;
        enc_nxt[DSC_BIT_WIRE_BREAK] = wire_break;
        enc_nxt[DSC_BIT_FRAME_ERR]  = frame_err;
        enc_nxt[DSC_BIT_ENC_SUPPLY] = enc_supply;
    end

    logic [7:0] mem_r;
    logic [7:0] io_r;
    logic [7:0] enc_r;

    // status bytes track current faults
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_r <= DSC_RST_BYTE;
            io_r  <= DSC_RST_BYTE;
            enc_r <= DSC_RST_BYTE;
        end else begin
            mem_r <= mem_nxt;
            io_r  <= io_nxt;
            enc_r <= enc_nxt;
        end
    end

    // ==========================================================
    // lamps and gated diagnostic interrupt
    logic [4:0] irq_src;
    logic       lamp_io_nxt;
    logic       irq_nxt;

    assign irq_src = {enc_r[DSC_BIT_ENC_SUPPLY], enc_r[DSC_BIT_FRAME_ERR],
                      enc_r[DSC_BIT_WIRE_BREAK], io_r[DSC_BIT_IO_SUPPLY],
                      mem_r[DSC_BIT_Q_OVERRUN]};
    assign irq_nxt = |(irq_src & irq_en_r);
    assign lamp_io_nxt = io_r[DSC_BIT_IO_SUPPLY] | (|enc_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_fault_lamp          <= 1'b0;
            high_supply_fault_lamp <= 1'b0;
            low_supply_fault_lamp  <= 1'b0;
            diag_irq               <= 1'b0;
        end else begin
            io_fault_lamp          <= lamp_io_nxt;
            high_supply_fault_lamp <= pins_s[6];
            low_supply_fault_lamp  <= pins_s[7];
            diag_irq               <= irq_nxt;
        end
    end

    // ==========================================================
    // apb decode, zero wait state
    logic        acc;
    logic        wr;
    logic        hit;
    logic [31:0] rd_mux;

    assign acc = psel && penable;
    assign wr  = acc && pwrite;
    assign hit = (paddr == DSC_OFF_MEM_ALARM) || (paddr == DSC_OFF_IO_SUPPLY)
              || (paddr == DSC_OFF_ENCODER) || (paddr == DSC_OFF_IRQ_EN)
              || (paddr == DSC_OFF_ENC_CFG) || (paddr == DSC_OFF_DIAG_IRQ);

    always_comb begin
        case (paddr)
            DSC_OFF_MEM_ALARM: rd_mux = {24'h000000, mem_r};
            DSC_OFF_IO_SUPPLY: rd_mux = {24'h000000, io_r};
            DSC_OFF_ENCODER:   rd_mux = {24'h000000, enc_r};
            DSC_OFF_IRQ_EN:    rd_mux = {27'h0000000, irq_en_r};
            DSC_OFF_ENC_CFG:   rd_mux = {30'h00000000, enc_sel_r};
            DSC_OFF_DIAG_IRQ:  rd_mux = {31'h00000000, diag_irq};
            default:           rd_mux = 32'h00000000;
        endcase
    end

    // config writes, read data capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_r  <= DSC_RST_IE;
            enc_sel_r <= DSC_RST_ENC;
            prdata    <= 32'h00000000;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
        end else begin
            if (wr && paddr == DSC_OFF_IRQ_EN) begin
                irq_en_r <= pwdata[4:0];
            end
            if (wr && paddr == DSC_OFF_ENC_CFG) begin
                enc_sel_r <= pwdata[1:0];
            end
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
        end
    end

    // ==========================================================
    // checks
    property p_io_missing;
        @(posedge pclk) disable iff (!presetn)
        io_missing |=> io_r[DSC_BIT_IO_SUPPLY];
    endproperty
    a_io_missing: assert property (p_io_missing)
        else $error("io supply bit not set");

    property p_flash;
        @(posedge pclk) disable iff (!presetn)
        flash_test_fail |=> mem_r[DSC_BIT_FLASH_FAIL];
    endproperty
    a_flash: assert property (p_flash)
        else $error("flash bit not set");

    property p_ram;
        @(posedge pclk) disable iff (!presetn)
        ram_test_fail |=> mem_r[DSC_BIT_RAM_FAIL];
    endproperty
    a_ram: assert property (p_ram)
        else $error("ram bit not set");

    property p_cpu;
        @(posedge pclk) disable iff (!presetn)
        cpu_test_fail |=> mem_r[DSC_BIT_CPU_FAIL];
    endproperty
    a_cpu: assert property (p_cpu)
        else $error("cpu bit not set");

    property p_overrun;
        @(posedge pclk) disable iff (!presetn)
        (pins_s[0] || pins_s[1]) |=> mem_r[DSC_BIT_Q_OVERRUN];
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun bit not set");

    property p_pair_a_only;
        @(posedge pclk) disable iff (!presetn)
        (serial_sel && pins_s[5:4] != 2'h0 && !pins_s[3] && $stable(serial_sel))
            |=> !enc_r[DSC_BIT_WIRE_BREAK];
    endproperty
    a_pair_a_only: assert property (p_pair_a_only)
        else $error("wire break from b or n pair in serial mode");

    property p_supply_lamp;
        @(posedge pclk) disable iff (!presetn)
        pins_s[6] |=> (high_supply_fault_lamp && enc_r[DSC_BIT_ENC_SUPPLY]);
    endproperty
    a_supply_lamp: assert property (p_supply_lamp)
        else $error("supply fault lamp or bit missing");

    property p_irq_gate;
        @(posedge pclk) disable iff (!presetn)
        ((irq_src & irq_en_r) == 5'h00) |=> !diag_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt without enable");

    property p_clear;
        @(posedge pclk) disable iff (!presetn)
        !enc_supply |=> !enc_r[DSC_BIT_ENC_SUPPLY];
    endproperty
    a_clear: assert property (p_clear)
        else $error("supply bit stuck after clear");

    property p_io_lamp;
        @(posedge pclk) disable iff (!presetn)
        io_r[DSC_BIT_IO_SUPPLY] |=> io_fault_lamp;
    endproperty
    a_io_lamp: assert property (p_io_lamp)
        else $error("io fault lamp dark with supply missing");

    property p_io_clear;
        @(posedge pclk) disable iff (!presetn)
        !io_missing |=> !io_r[DSC_BIT_IO_SUPPLY];
    endproperty
    a_io_clear: assert property (p_io_clear)
        else $error("io supply bit stuck after return");

    property p_local_overrun;
        @(posedge pclk) disable iff (!presetn)
        pins_s[1] |=> mem_r[DSC_BIT_Q_OVERRUN];
    endproperty
    a_local_overrun: assert property (p_local_overrun)
        else $error("local overrun not reported");

    property p_wire_break;
        @(posedge pclk) disable iff (!presetn)
        wire_break |=> enc_r[DSC_BIT_WIRE_BREAK];
    endproperty
    a_wire_break: assert property (p_wire_break)
        else $error("wire break bit not set");

    property p_frame_err;
        @(posedge pclk) disable iff (!presetn)
        frame_err |=> enc_r[DSC_BIT_FRAME_ERR];
    endproperty
    a_frame_err: assert property (p_frame_err)
        else $error("frame error bit not set");

    property p_frame_idle;
        @(posedge pclk) disable iff (!presetn)
        !serial_sel |=> !enc_r[DSC_BIT_FRAME_ERR];
    endproperty
    a_frame_idle: assert property (p_frame_idle)
        else $error("frame error without serial encoder");

    property p_low_lamp;
        @(posedge pclk) disable iff (!presetn)
        pins_s[7] |=> (low_supply_fault_lamp && enc_r[DSC_BIT_ENC_SUPPLY]);
    endproperty
    a_low_lamp: assert property (p_low_lamp)
        else $error("low supply lamp or bit missing");

    property p_irq_set;
        @(posedge pclk) disable iff (!presetn)
        ((irq_src & irq_en_r) != 5'h00) |=> diag_irq;
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("enabled diagnostic gave no interrupt");
endmodule // dsc_top

// file: verif/dsc_host_model.sv
// host controller model: apb master and diagnostic interpretation
`timescale 1ns/100ps
module dsc_host_model
    import dsc_pkg::*;
(
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // ==========================================================
    // bus idle state
    int hung = 0;
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h00000000;
    end

    // ==========================================================
    // one transfer: setup, access until pready, then release
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        if (n >= 50) begin
            hung = 1;
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // ==========================================================
    // trust of the other bits while a supply fault stands
    function automatic logic io_trust(input logic [31:0] b8);
        return !b8[DSC_BIT_IO_SUPPLY];
    endfunction
    function automatic logic pos_trust(input logic [31:0] b13);
        return !b13[DSC_BIT_ENC_SUPPLY];
    endfunction
endmodule // dsc_host_model

// file: verif/testbench.sv
// self-checking bench for the diagnostic status collector
`timescale 1ns/100ps
module testbench;
    import dsc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [4:0]  alarm;
    logic [2:0]  diff_pair_fault, lamps;
    logic io_supply_input, high_supply_overload, low_supply_overload;
    logic frame_done, frame_bad, io_fault_lamp, diag_irq;
    logic high_supply_fault_lamp, low_supply_fault_lamp;
    int   errors = 0;
    int   n_compared = 0;
    int   pos[5] = '{DSC_BIT_CPU_FAIL, DSC_BIT_FLASH_FAIL, DSC_BIT_RAM_FAIL,
                     DSC_BIT_Q_OVERRUN, DSC_BIT_Q_OVERRUN};
    assign lamps = {io_fault_lamp, high_supply_fault_lamp,
                    low_supply_fault_lamp};

    // ==========================================================
    // clock and instances
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    dsc_host_model host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    dsc_top u_dsc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_test_fail(alarm[0]), .flash_test_fail(alarm[1]),
        .ram_test_fail(alarm[2]), .host_queue_overrun(alarm[3]),
        .local_queue_overrun(alarm[4]), .io_supply_input(io_supply_input),
        .diff_pair_fault(diff_pair_fault),
        .high_supply_overload(high_supply_overload),
        .low_supply_overload(low_supply_overload), .frame_done(frame_done),
        .frame_bad(frame_bad), .io_fault_lamp(io_fault_lamp),
        .high_supply_fault_lamp(high_supply_fault_lamp),
        .low_supply_fault_lamp(low_supply_fault_lamp), .diag_irq(diag_irq));

    // ==========================================================
    // checking and access helpers
    task automatic summarize;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x,
                       input string m);
        n_compared++;
        if (g !== x) begin
            errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, x);
        end
        if (host.hung != 0) begin
            errors++;
            summarize();
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [31:0] x,
                       input logic xe);
        logic e;
        host.xfer(w, a, d, rdata, e);
        chk({31'h0, e}, {31'h0, xe}, "slave error");
        if (!w) begin
            chk(rdata, x, "read data");
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        acc(1'b1, a, d, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        acc(1'b0, a, 32'h0, x, 1'b0);
    endtask
    task automatic settle;
        repeat (8) @(posedge pclk);
    endtask
    task automatic frame(input logic bad);
        @(posedge pclk);
        frame_bad  <= bad;
        frame_done <= 1'b1;
        repeat (6) @(posedge pclk);
        frame_done <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        presetn = 1'b0;
        alarm = 5'h00;
        io_supply_input = 1'b1;
        diff_pair_fault = 3'h0;
        high_supply_overload = 1'b0;
        low_supply_overload = 1'b0;
        frame_done = 1'b0;
        frame_bad = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        // reset contents, read-only bytes, unmapped place
        rd(DSC_OFF_MEM_ALARM, 32'h0);
        rd(DSC_OFF_IO_SUPPLY, 32'h0);
        wr(DSC_OFF_ENCODER, 32'hFF);
        rd(DSC_OFF_ENCODER, 32'h0);
        rd(DSC_OFF_IRQ_EN, 32'h0);
        acc(1'b0, 12'h004, 32'h0, 32'h0, 1'b1);
        // supply missing, interrupt masking
        @(posedge pclk);
        io_supply_input <= 1'b0;
        settle();
        rd(DSC_OFF_IO_SUPPLY, 32'h20);
        chk({31'h0, host.io_trust(rdata)}, 32'h0, "io trust");
        chk({29'h0, lamps}, 32'h4, "io lamp");
        wr(DSC_OFF_IRQ_EN, 32'h1D);
        settle();
        chk({31'h0, diag_irq}, 32'h0, "irq masked");
        wr(DSC_OFF_IRQ_EN, 32'hFFFFFFFF);
        rd(DSC_OFF_IRQ_EN, 32'h1F);
        settle();
        chk({31'h0, diag_irq}, 32'h1, "irq enabled");
        rd(DSC_OFF_DIAG_IRQ, 32'h1);
        @(posedge pclk);
        io_supply_input <= 1'b1;
        settle();
        rd(DSC_OFF_IO_SUPPLY, 32'h0);
        chk({31'h0, diag_irq}, 32'h0, "irq cleared");
        // memory and queue alarms one by one
        for (int i = 0; i < 5; i++) begin
            @(posedge pclk);
            alarm <= 5'h01 << i;
            settle();
            rd(DSC_OFF_MEM_ALARM, 32'h1 << pos[i]);
            chk({31'h0, diag_irq}, {31'h0, i >= 3}, "overrun irq");
            @(posedge pclk);
            alarm <= 5'h00;
            settle();
            rd(DSC_OFF_MEM_ALARM, 32'h0);
        end
        // wire break, all pairs when differential
        wr(DSC_OFF_ENC_CFG, {30'h0, DSC_ENC_DIFF});
        for (int p = 0; p < 3; p++) begin
            @(posedge pclk);
            diff_pair_fault <= 3'h1 << p;
            settle();
            rd(DSC_OFF_ENCODER, 32'h01);
            chk({29'h0, lamps}, 32'h4, "break lamp");
            @(posedge pclk);
            diff_pair_fault <= 3'h0;
            settle();
            rd(DSC_OFF_ENCODER, 32'h0);
        end
        // serial selected: only pair a, then frame checks
        wr(DSC_OFF_ENC_CFG, {30'h0, DSC_ENC_SERIAL});
        frame(1'b0);
        @(posedge pclk);
        diff_pair_fault <= 3'h6;
        settle();
        rd(DSC_OFF_ENCODER, 32'h0);
        @(posedge pclk);
        diff_pair_fault <= 3'h1;
        settle();
        rd(DSC_OFF_ENCODER, 32'h01);
        @(posedge pclk);
        diff_pair_fault <= 3'h0;
        frame(1'b1);
        rd(DSC_OFF_ENCODER, 32'h02);
        frame(1'b0);
        rd(DSC_OFF_ENCODER, 32'h0);
        repeat (4100) @(posedge pclk);
        rd(DSC_OFF_ENCODER, 32'h02);
        wr(DSC_OFF_ENC_CFG, {30'h0, DSC_ENC_NONE});
        settle();
        rd(DSC_OFF_ENCODER, 32'h0);
        // encoder supply overloads and their lamps
        @(posedge pclk);
        high_supply_overload <= 1'b1;
        settle();
        rd(DSC_OFF_ENCODER, 32'h08);
        chk({31'h0, host.pos_trust(rdata)}, 32'h0, "pos trust");
        chk({29'h0, lamps}, 32'h6, "high lamps");
        chk({31'h0, diag_irq}, 32'h1, "supply irq");
        wr(DSC_OFF_IRQ_EN, 32'h0F);
        settle();
        chk({31'h0, diag_irq}, 32'h0, "supply irq off");
        @(posedge pclk);
        high_supply_overload <= 1'b0;
        low_supply_overload <= 1'b1;
        settle();
        chk({29'h0, lamps}, 32'h5, "low lamps");
        @(posedge pclk);
        low_supply_overload <= 1'b0;
        settle();
        rd(DSC_OFF_ENCODER, 32'h0);
        chk({29'h0, lamps}, 32'h0, "lamps off");
        summarize();
    end
endmodule // testbench
